//--- hw/ufr_pkg.sv
// Constants and types shared by the UART flash reprogramming sequencer.
package ufr_pkg;
	localparam int CLK_FREQ_HZ = 10_000_000;
	localparam int BAUD_RATE = 115200;
	localparam int BAUD_DIV = (CLK_FREQ_HZ + BAUD_RATE / 2) / BAUD_RATE;
	localparam int FIFO_DEPTH = 8;
	localparam int ADDR_W = 20;
	localparam int BLK_OFS_W = 10;
	localparam int BLK_W = ADDR_W - BLK_OFS_W;
	localparam logic [7:0] PKT_START_CODE = 8'h01;
	localparam logic [7:0] CMD_START = 8'h02;
	localparam logic [7:0] CMD_WRITE = 8'h03;
	localparam logic [7:0] CMD_END = 8'h04;
	localparam logic [7:0] RESP_NORMAL = 8'h01;
	localparam logic [15:0] LEN_SHORT = 16'h0002;
	localparam logic [15:0] LEN_WRITE = 16'h0102;
	localparam logic [7:0] CHUNK_LAST = 8'hff;
	localparam logic [ADDR_W-1:0] WRITE_BASE_ADDR = 20'h01000;
	localparam logic [7:0] WIN_START_BLK = 8'h00;
	localparam logic [7:0] WIN_END_BLK = 8'h3f;
	localparam logic [7:0] VOLT_FULL_SPEED = 8'h00;
	localparam logic [7:0] FREQ_ARG_MHZ = 8'h20;
	localparam logic [7:0] STATUS_INTERNAL = 8'h01;
	typedef enum logic [3:0] {
		FL_NONE = 4'h0,
		FL_INIT = 4'h1,
		FL_GET_WIN = 4'h2,
		FL_SET_WIN = 4'h3,
		FL_BLANK = 4'h4,
		FL_ERASE = 4'h5,
		FL_WRITE = 4'h6,
		FL_VERIFY = 4'h7,
		FL_TOGGLE_BOOT = 4'h8,
		FL_RESET = 4'h9
	} ufr_flop_t;
endpackage : ufr_pkg

//--- hw/ufr_stream_if.sv
// Valid/ready byte stream between the sequencer's own modules.
`timescale 1ns/1ps
`default_nettype none
interface ufr_stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface : ufr_stream_if
`default_nettype wire

//--- hw/ufr_fifo.sv
// Small valid/ready FIFO in the received data path.
`timescale 1ns/1ps
`default_nettype none
module ufr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
)(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	ufr_stream_if.snk in_s,
	ufr_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	////////////////////////////////////////////////////////////////////////////////
	assign in_s.ready = (cnt_q != (AW+1)'(DEPTH));
	assign out_s.valid = (cnt_q != '0);
	assign out_s.data = mem_q[rp_q];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb
	begin
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (push)
		begin
			wp_d = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
		end
		if (pop)
		begin
			rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
		end
		if (push && !pop)
		begin
			cnt_d = cnt_q + 1'b1;
		end
		else if (pop && !push)
		begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_ent
		always_ff @(posedge i_clk_sys or negedge i_rst_n)
		begin
			if (!i_rst_n)
			begin
				mem_q[i] <= '0;
			end
			else if (push && wp_q == AW'(i))
			begin
				mem_q[i] <= in_s.data;
			end
		end
	end
endmodule : ufr_fifo
`default_nettype wire

//--- hw/ufr_uart.sv
// Serial receiver and transmitter, 8 data bits, no parity, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module ufr_uart
	import ufr_pkg::*;
#(
	parameter int DIV = BAUD_DIV
)(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_rx,
	ufr_stream_if.src rx_s,
	output logic o_overrun,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	output logic o_tx
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] FULL = CW'(DIV - 1);
	localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);
	logic [1:0] sync_q;
	logic rbusy_q, rbusy_d, rval_q, rval_d, ovr_q, ovr_d, tbusy_q, tbusy_d;
	logic [CW-1:0] rcnt_q, rcnt_d, tcnt_q, tcnt_d;
	logic [3:0] rbit_q, rbit_d, tbit_q, tbit_d;
	logic [7:0] rsh_q, rsh_d, rdat_q, rdat_d;
	logic [9:0] tsh_q, tsh_d;

	assign rx_s.valid = rval_q;
	assign rx_s.data = rdat_q;
	assign o_overrun = ovr_q;
	assign o_tx_ready = !tbusy_q;
	assign o_tx = tsh_q[0];

	////////////////////////////////////////////////////////////////////////////////
	// LSB first framing
	always_comb
	begin
		rbusy_d = rbusy_q;
		rcnt_d = rcnt_q;
		rbit_d = rbit_q;
		rsh_d = rsh_q;
		rdat_d = rdat_q;
		rval_d = rval_q && !rx_s.ready;
		ovr_d = 1'b0;
		if (!rbusy_q)
		begin
			if (!sync_q[1])
			begin
				rbusy_d = 1'b1;
				rcnt_d = HALF;
				rbit_d = 4'h0;
			end
		end
		else if (rcnt_q != '0)
		begin
			rcnt_d = rcnt_q - 1'b1;
		end
		else
		begin
			rcnt_d = FULL;
			rbit_d = rbit_q + 1'b1;
			if (rbit_q == 4'h0 && sync_q[1])
			begin
				rbusy_d = 1'b0;
			end
			else if (rbit_q != 4'h0 && rbit_q != 4'h9)
			begin
				rsh_d = {sync_q[1], rsh_q[7:1]};
			end
			else if (rbit_q == 4'h9)
			begin
				rbusy_d = 1'b0;
				if (sync_q[1])
				begin
					ovr_d = rval_d;
					rdat_d = rsh_q;
					rval_d = 1'b1;
				end
			end
		end
	end

	// The line idles high; a spurious start edge is dropped at mid start bit.
	always_comb
	begin
		tbusy_d = tbusy_q;
		tcnt_d = tcnt_q;
		tbit_d = tbit_q;
		tsh_d = tsh_q;
		if (!tbusy_q)
		begin
			if (i_tx_valid)
			begin
				tbusy_d = 1'b1;
				tcnt_d = FULL;
				tbit_d = 4'h0;
				tsh_d = {1'b1, i_tx_data, 1'b0};
			end
		end
		else if (tcnt_q != '0)
		begin
			tcnt_d = tcnt_q - 1'b1;
		end
		else
		begin
			tcnt_d = FULL;
			tsh_d = {1'b1, tsh_q[9:1]};
			tbit_d = tbit_q + 1'b1;
			tbusy_d = (tbit_q != 4'h9);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sync_q <= 2'h3;
			rbusy_q <= 1'b0;
			rcnt_q <= '0;
			rbit_q <= 4'h0;
			rsh_q <= 8'h00;
			rdat_q <= 8'h00;
			rval_q <= 1'b0;
			ovr_q <= 1'b0;
			tbusy_q <= 1'b0;
			tcnt_q <= '0;
			tbit_q <= 4'h0;
			tsh_q <= 10'h3ff;
		end
		else
		begin
			sync_q <= {sync_q[0], i_rx};
			rbusy_q <= rbusy_d;
			rcnt_q <= rcnt_d;
			rbit_q <= rbit_d;
			rsh_q <= rsh_d;
			rdat_q <= rdat_d;
			rval_q <= rval_d;
			ovr_q <= ovr_d;
			tbusy_q <= tbusy_d;
			tcnt_q <= tcnt_d;
			tbit_q <= tbit_d;
			tsh_q <= tsh_d;
		end
	end
endmodule : ufr_uart
`default_nettype wire

//--- hw/ufr_sequencer.sv
// Packet interpreter that drives flash reprogramming from the serial link.
`timescale 1ns/1ps
`default_nettype none
module ufr_sequencer
	import ufr_pkg::*;
#(
	parameter int DIV = BAUD_DIV
)(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_serial_rx_pin,
	output logic o_serial_tx_pin,
	output logic o_flash_access_led_pin,
	output logic o_halt,
	output logic o_error,
	output logic o_fl_req,
	output ufr_flop_t o_fl_op,
	output logic [ADDR_W-1:0] o_fl_addr,
	output logic [BLK_W-1:0] o_fl_blk,
	output logic [7:0] o_fl_wdata,
	output logic [23:0] o_fl_arg,
	input wire logic i_fl_done,
	input wire logic i_fl_fail,
	input wire logic i_fl_blank,
	input wire logic [7:0] i_fl_win_start,
	input wire logic [7:0] i_fl_win_end
);
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00000,
		ST_LEN_HI = 5'b00001,
		ST_LEN_LO = 5'b00010,
		ST_CMD = 5'b00011,
		ST_DATA = 5'b00100,
		ST_SUM = 5'b00101,
		ST_INIT = 5'b00110,
		ST_GET_WIN = 5'b00111,
		ST_SET_WIN = 5'b01000,
		ST_BLANK = 5'b01001,
		ST_ERASE = 5'b01010,
		ST_WRITE = 5'b01011,
		ST_VERIFY = 5'b01100,
		ST_TOGGLE = 5'b01101,
		ST_RESET = 5'b01110,
		ST_RESP = 5'b01111,
		ST_ERROR = 5'b10000
	} ufr_state_t;

	ufr_state_t state_q, state_d;
	ufr_flop_t op_q, op_d;
	logic [15:0] len_q, len_d;
	logic [7:0] cmd_q, cmd_d, sum_q, sum_d, byte_q, byte_d, cnt_q, cnt_d;
	logic [ADDR_W-1:0] ptr_q, ptr_d;
	logic [BLK_W-1:0] blk_q, blk_d;
	logic [23:0] arg_q, arg_d;
	logic session_q, session_d, led_on_q, led_on_d, err_q, err_d;
	logic consuming, take, fl_ok, overrun, tx_ready, tx_valid;

	ufr_stream_if #(.W(8)) rx_if ();
	ufr_stream_if #(.W(8)) q_if ();

	////////////////////////////////////////////////////////////////////////////////
	ufr_uart #(
		.DIV(DIV)
	) u_uart (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_rx(i_serial_rx_pin),
		.rx_s(rx_if.src),
		.o_overrun(overrun),
		.i_tx_data(RESP_NORMAL),
		.i_tx_valid(tx_valid),
		.o_tx_ready(tx_ready),
		.o_tx(o_serial_tx_pin)
	);

	// Eight bytes cover the flash agent's latency per byte; a slower agent overruns.
	ufr_fifo #(
		.W(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.in_s(rx_if.snk),
		.out_s(q_if.src)
	);

	function automatic ufr_flop_t op_of(input ufr_state_t s);
		case (s)
			ST_INIT: op_of = FL_INIT;
			ST_GET_WIN: op_of = FL_GET_WIN;
			ST_SET_WIN: op_of = FL_SET_WIN;
			ST_BLANK: op_of = FL_BLANK;
			ST_ERASE: op_of = FL_ERASE;
			ST_WRITE: op_of = FL_WRITE;
			ST_VERIFY: op_of = FL_VERIFY;
			ST_TOGGLE: op_of = FL_TOGGLE_BOOT;
			ST_RESET: op_of = FL_RESET;
			default: op_of = FL_NONE;
		endcase
	endfunction : op_of

	////////////////////////////////////////////////////////////////////////////////
	assign consuming = (state_q == ST_IDLE) || (state_q == ST_LEN_HI) || (state_q == ST_LEN_LO)
		|| (state_q == ST_CMD) || (state_q == ST_DATA) || (state_q == ST_SUM);
	assign q_if.ready = consuming;
	assign take = q_if.valid && consuming;
	assign fl_ok = i_fl_done && !i_fl_fail;
	assign tx_valid = (state_q == ST_RESP);
	assign o_halt = (state_q == ST_IDLE) && !q_if.valid;
	assign o_error = err_q;
	assign o_flash_access_led_pin = !led_on_q;
	assign o_fl_req = (op_q != FL_NONE);
	assign o_fl_op = op_q;
	assign o_fl_addr = ptr_q;
	assign o_fl_blk = blk_q;
	assign o_fl_wdata = byte_q;
	assign o_fl_arg = arg_q;

	always_comb
	begin
		state_d = state_q;
		len_d = len_q;
		cmd_d = cmd_q;
		sum_d = sum_q;
		byte_d = byte_q;
		cnt_d = cnt_q;
		ptr_d = ptr_q;
		blk_d = blk_q;
		session_d = session_q;
		led_on_d = led_on_q;
		case (state_q)
			ST_IDLE:
			begin
				if (take && q_if.data == PKT_START_CODE)
				begin
					state_d = ST_LEN_HI;
				end
			end
			ST_LEN_HI:
			begin
				if (take)
				begin
					len_d = {q_if.data, 8'h00};
					state_d = ST_LEN_LO;
				end
			end
			ST_LEN_LO:
			begin
				if (take)
				begin
					len_d = {len_q[15:8], q_if.data};
					state_d = ST_CMD;
				end
			end
			ST_CMD:
			begin
				if (take)
				begin
					cmd_d = q_if.data;
					sum_d = q_if.data;
					cnt_d = 8'h00;
					state_d = ST_ERROR;
					if (q_if.data == CMD_START && !session_q && len_q == LEN_SHORT)
					begin
						state_d = ST_SUM;
					end
					else if (q_if.data == CMD_END && session_q && len_q == LEN_SHORT)
					begin
						state_d = ST_SUM;
					end
					else if (q_if.data == CMD_WRITE && session_q && len_q == LEN_WRITE)
					begin
						if (ptr_q[BLK_OFS_W-1:0] == '0)
						begin
							blk_d = ptr_q[ADDR_W-1:BLK_OFS_W];
							state_d = ST_BLANK;
						end
						else
						begin
							state_d = ST_DATA;
						end
					end
				end
			end
			ST_BLANK:
			begin
				if (fl_ok)
				begin
					state_d = i_fl_blank ? ST_DATA : ST_ERASE;
				end
			end
			ST_ERASE:
			begin
				if (fl_ok)
				begin
					state_d = ST_DATA;
				end
			end
			ST_DATA:
			begin
				if (take)
				begin
					sum_d = sum_q + q_if.data;
					byte_d = q_if.data;
					state_d = ST_WRITE;
				end
			end
			ST_WRITE:
			begin
				if (fl_ok)
				begin
					ptr_d = ptr_q + 1'b1;
					cnt_d = cnt_q + 1'b1;
					state_d = (cnt_q == CHUNK_LAST) ? ST_SUM : ST_DATA;
				end
			end
			ST_SUM:
			begin
				if (take)
				begin
					if (q_if.data != sum_q)
					begin
						state_d = ST_ERROR;
					end
					else if (cmd_q == CMD_START)
					begin
						led_on_d = 1'b1;
						state_d = ST_INIT;
					end
					else if (cmd_q == CMD_WRITE)
					begin
						state_d = (ptr_q[BLK_OFS_W-1:0] == '0) ? ST_VERIFY : ST_RESP;
					end
					else
					begin
						state_d = (ptr_q[BLK_OFS_W-1:0] != '0) ? ST_VERIFY : ST_TOGGLE;
					end
				end
			end
			ST_INIT:
			begin
				if (fl_ok)
				begin
					state_d = ST_GET_WIN;
				end
			end
			ST_GET_WIN:
			begin
				if (fl_ok)
				begin
					if (i_fl_win_start != WIN_START_BLK || i_fl_win_end != WIN_END_BLK)
					begin
						state_d = ST_SET_WIN;
					end
					else
					begin
						ptr_d = WRITE_BASE_ADDR;
						session_d = 1'b1;
						state_d = ST_RESP;
					end
				end
			end
			ST_SET_WIN:
			begin
				if (fl_ok)
				begin
					ptr_d = WRITE_BASE_ADDR;
					session_d = 1'b1;
					state_d = ST_RESP;
				end
			end
			ST_VERIFY:
			begin
				if (fl_ok)
				begin
					state_d = (cmd_q == CMD_END) ? ST_TOGGLE : ST_RESP;
				end
			end
			ST_TOGGLE:
			begin
				if (fl_ok)
				begin
					led_on_d = 1'b0;
					session_d = 1'b0;
					state_d = ST_RESET;
				end
			end
			ST_RESET:
			begin
				state_d = ST_RESET;
			end
			ST_RESP:
			begin
				if (tx_ready)
				begin
					state_d = ST_IDLE;
				end
			end
			ST_ERROR:
			begin
				state_d = ST_ERROR;
			end
			default:
			begin
				state_d = ST_ERROR;
			end
		endcase
		if ((op_q != FL_NONE && i_fl_done && i_fl_fail) || overrun)
		begin
			state_d = ST_ERROR;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		op_d = op_of(state_d);
		err_d = err_q || (state_d == ST_ERROR);
		arg_d = 24'h000000;
		if (state_d == ST_INIT)
		begin
			arg_d = {VOLT_FULL_SPEED, FREQ_ARG_MHZ, STATUS_INTERNAL};
		end
		else if (state_d == ST_SET_WIN)
		begin
			arg_d = {8'h00, WIN_START_BLK, WIN_END_BLK};
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= ST_IDLE;
			op_q <= FL_NONE;
			len_q <= 16'h0000;
			cmd_q <= 8'h00;
			sum_q <= 8'h00;
			byte_q <= 8'h00;
			cnt_q <= 8'h00;
			ptr_q <= '0;
			blk_q <= '0;
			arg_q <= 24'h000000;
			session_q <= 1'b0;
			led_on_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			len_q <= len_d;
			cmd_q <= cmd_d;
			sum_q <= sum_d;
			byte_q <= byte_d;
			cnt_q <= cnt_d;
			ptr_q <= ptr_d;
			blk_q <= blk_d;
			arg_q <= arg_d;
			session_q <= session_d;
			led_on_q <= led_on_d;
			err_q <= err_d;
		end
	end
endmodule : ufr_sequencer
`default_nettype wire

//--- dv/ufr_sequencer_assertions.sv
// Port-level checks of the flash reprogramming sequencer.
`timescale 1ns/1ps
`default_nettype none
module ufr_sequencer_checker
	import ufr_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_serial_rx_pin,
	input wire logic o_serial_tx_pin,
	input wire logic o_flash_access_led_pin,
	input wire logic o_halt,
	input wire logic o_error,
	input wire logic o_fl_req,
	input wire ufr_flop_t o_fl_op,
	input wire logic [ADDR_W-1:0] o_fl_addr,
	input wire logic [BLK_W-1:0] o_fl_blk,
	input wire logic [7:0] o_fl_wdata,
	input wire logic [23:0] o_fl_arg,
	input wire logic i_fl_done,
	input wire logic i_fl_fail,
	input wire logic i_fl_blank,
	input wire logic [7:0] i_fl_win_start,
	input wire logic [7:0] i_fl_win_end
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// The write step is only judged at the edge that takes the agent's answer.
	logic wr_done;
	assign wr_done = o_fl_req && (o_fl_op == FL_WRITE) && i_fl_done;
	a_init_arg: assert property (o_fl_req && o_fl_op == FL_INIT |-> o_fl_arg == 24'h002001)
		else $error("init argument wrong");
	a_win_arg: assert property (o_fl_req && o_fl_op == FL_SET_WIN |-> o_fl_arg == {8'h00, WIN_START_BLK, WIN_END_BLK})
		else $error("window argument wrong");
	a_led_on_init: assert property (o_fl_req && o_fl_op == FL_INIT |-> !o_flash_access_led_pin)
		else $error("indicator off during init");
	a_led_off_reset: assert property (o_fl_req && o_fl_op == FL_RESET |-> o_flash_access_led_pin)
		else $error("indicator on at reset");
	a_blk_from_addr: assert property (o_fl_req && o_fl_op inside {FL_BLANK, FL_ERASE} |-> o_fl_blk == o_fl_addr[ADDR_W-1:BLK_OFS_W] && o_fl_addr[BLK_OFS_W-1:0] == 10'h000)
		else $error("block index not from pointer");
	a_write_step: assert property (wr_done |=> o_fl_addr == $past(o_fl_addr) + 20'h00001)
		else $error("pointer did not advance");
	a_error_sticky: assert property (o_error |=> o_error)
		else $error("error stop left");
	a_error_no_req: assert property (o_error |=> !o_fl_req)
		else $error("request after error");
	a_error_quiet: assert property (o_error |-> o_serial_tx_pin[*3])
		else $error("transmit after error");
	c_erase: cover property (o_fl_req && o_fl_op == FL_ERASE);
	c_write: cover property (wr_done);
	c_reset: cover property (o_fl_req && o_fl_op == FL_RESET);
	c_error: cover property ($rose(o_error));
endmodule : ufr_sequencer_checker
bind ufr_sequencer ufr_sequencer_checker u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
	.i_serial_rx_pin(i_serial_rx_pin), .o_serial_tx_pin(o_serial_tx_pin), .o_flash_access_led_pin(o_flash_access_led_pin),
	.o_halt(o_halt), .o_error(o_error), .o_fl_req(o_fl_req), .o_fl_op(o_fl_op), .o_fl_addr(o_fl_addr),
	.o_fl_blk(o_fl_blk), .o_fl_wdata(o_fl_wdata), .o_fl_arg(o_fl_arg), .i_fl_done(i_fl_done), .i_fl_fail(i_fl_fail),
	.i_fl_blank(i_fl_blank), .i_fl_win_start(i_fl_win_start), .i_fl_win_end(i_fl_win_end));
`default_nettype wire

//--- dv/ufr_host_model.sv
// Sending host: packet transmitter and response receiver on the serial link.
`timescale 1ns/1ps
`default_nettype none
module ufr_host_model
	import ufr_pkg::*;
#(
	parameter int DIV = BAUD_DIV
)(
	input wire logic i_clk_sys,
	input wire logic i_tx,
	output logic o_rx
);
	logic [7:0] resp_q [$];
	logic [7:0] rb;
	initial o_rx = 1'b1;
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] sh;
		sh = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge i_clk_sys);
			#1 o_rx = sh[i];
			repeat (DIV - 1) @(posedge i_clk_sys);
		end
	endtask : send_byte
	task automatic send_pkt(input logic [7:0] cmd, input int n, input logic [7:0] bad);
		logic [15:0] len;
		logic [7:0] sum;
		len = 16'(n + 2);
		sum = cmd;
		send_byte(PKT_START_CODE);
		send_byte(len[15:8]);
		send_byte(len[7:0]);
		send_byte(cmd);
		for (int i = 0; i < n; i++)
		begin
			send_byte(8'(i));
			sum = sum + 8'(i);
		end
		send_byte(sum ^ bad);
	endtask : send_pkt
	initial forever
	begin
		@(posedge i_clk_sys);
		// Look just after the edge so the start bit launched on it is settled.
		#1;
		if (i_tx === 1'b0)
		begin
			repeat (DIV / 2) @(posedge i_clk_sys);
			for (int k = 0; k < 8; k++)
			begin
				repeat (DIV) @(posedge i_clk_sys);
				rb[k] = i_tx;
			end
			resp_q.push_back(rb);
			repeat (DIV) @(posedge i_clk_sys);
		end
	end
endmodule : ufr_host_model
`default_nettype wire

//--- dv/ufr_sequencer_test.sv
// Self-checking bench of the flash reprogramming sequencer.
`timescale 1ns/1ps
`default_nettype none
module ufr_sequencer_test
	import ufr_pkg::*;
;
	logic i_clk_sys, i_rst_n, o_serial_tx_pin, o_flash_access_led_pin, o_halt, o_error, o_fl_req;
	wire logic i_serial_rx_pin;
	ufr_flop_t o_fl_op, last_op, fail_op;
	logic [ADDR_W-1:0] o_fl_addr;
	logic [BLK_W-1:0] o_fl_blk;
	logic [7:0] o_fl_wdata, i_fl_win_start, i_fl_win_end;
	logic [23:0] o_fl_arg;
	logic i_fl_done, i_fl_fail, i_fl_blank, served;
	int wait_n, wr_n, wr_bad, errors, checks_done;
	ufr_flop_t op_q [$];
	logic [BLK_W-1:0] blk_q [$];
	// A short bit time keeps a 256-byte write packet well inside the run budget.
	localparam int TB_DIV = 16;
	ufr_host_model #(.DIV(TB_DIV)) u_host (.i_clk_sys(i_clk_sys), .i_tx(o_serial_tx_pin), .o_rx(i_serial_rx_pin));
	ufr_sequencer #(.DIV(TB_DIV)) u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_serial_rx_pin(i_serial_rx_pin),
		.o_serial_tx_pin(o_serial_tx_pin), .o_flash_access_led_pin(o_flash_access_led_pin), .o_halt(o_halt),
		.o_error(o_error), .o_fl_req(o_fl_req), .o_fl_op(o_fl_op), .o_fl_addr(o_fl_addr), .o_fl_blk(o_fl_blk),
		.o_fl_wdata(o_fl_wdata), .o_fl_arg(o_fl_arg), .i_fl_done(i_fl_done), .i_fl_fail(i_fl_fail),
		.i_fl_blank(i_fl_blank), .i_fl_win_start(i_fl_win_start), .i_fl_win_end(i_fl_win_end));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Flash agent answers each new request two cycles late; a changed op counts as new.
	always @(posedge i_clk_sys)
	begin
		#1 i_fl_done = 1'b0;
		if (o_fl_req !== 1'b1)
		begin
			served = 1'b0;
			wait_n = 0;
		end
		else if (!served || o_fl_op !== last_op)
		begin
			wait_n++;
			if (wait_n == 3)
			begin
				i_fl_done = 1'b1;
				i_fl_fail = (o_fl_op === fail_op);
				served = 1'b1;
				last_op = o_fl_op;
				wait_n = 0;
				op_q.push_back(o_fl_op);
				blk_q.push_back(o_fl_blk);
				if (o_fl_op === FL_WRITE)
				begin
					if (o_fl_addr !== WRITE_BASE_ADDR + ADDR_W'(wr_n) || o_fl_wdata !== 8'(wr_n))
						wr_bad++;
					wr_n++;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask : chk_bit
	task automatic chk_op(input ufr_flop_t got, input ufr_flop_t exp, input string what);
		chk_bit(got === exp, 1'b1, what);
	endtask : chk_op
	task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp, input string what);
		chk_bit(got === exp, 1'b1, what);
	endtask : chk_vec
	task automatic end_of_test;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task automatic do_reset;
		#1 i_rst_n = 1'b0;
		op_q.delete();
		blk_q.delete();
		u_host.resp_q.delete();
		repeat (10) @(posedge i_clk_sys);
		#1 i_rst_n = 1'b1;
	endtask : do_reset
	task automatic wait_resp(input int n);
		for (int i = 0; i < 6000 && u_host.resp_q.size() < n; i++) @(posedge i_clk_sys);
	endtask : wait_resp
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_start;
		i_fl_win_start = 8'h05;
		chk_bit(o_halt, 1'b1, "not halted when idle");
		u_host.send_pkt(CMD_START, 0, 8'h00);
		wait_resp(1);
		chk_bit(o_flash_access_led_pin, 1'b0, "indicator not on");
		chk_vec(32'(op_q.size()), 32'd3, "start op count");
		chk_op(op_q[0], FL_INIT, "init not first");
		chk_op(op_q[1], FL_GET_WIN, "window not read");
		chk_op(op_q[2], FL_SET_WIN, "window not set");
		chk_vec(32'(u_host.resp_q[0]), 32'(RESP_NORMAL), "start answer");
	endtask : t_start
	task automatic t_write;
		i_fl_blank = 1'b0;
		op_q.delete();
		blk_q.delete();
		u_host.send_pkt(CMD_WRITE, 256, 8'h00);
		wait_resp(2);
		chk_op(op_q[0], FL_BLANK, "no blank check");
		chk_vec(32'(blk_q[0]), 32'(WRITE_BASE_ADDR >> BLK_OFS_W), "blank block");
		chk_op(op_q[1], FL_ERASE, "no erase");
		chk_vec(32'(wr_n), 32'd256, "byte writes");
		chk_vec(32'(wr_bad), 32'd0, "write address or data");
		chk_vec(32'(op_q.size()), 32'd258, "verify in open block");
		chk_vec(32'(u_host.resp_q[1]), 32'(RESP_NORMAL), "write answer");
	endtask : t_write
	task automatic t_end;
		op_q.delete();
		blk_q.delete();
		u_host.send_pkt(CMD_END, 0, 8'h00);
		for (int i = 0; i < 3000 && o_fl_op !== FL_RESET; i++) @(posedge i_clk_sys);
		repeat (1000) @(posedge i_clk_sys);
		chk_op(op_q[0], FL_VERIFY, "no verify on end");
		chk_vec(32'(blk_q[0]), 32'(WRITE_BASE_ADDR >> BLK_OFS_W), "verify block");
		chk_op(op_q[1], FL_TOGGLE_BOOT, "no boot toggle");
		chk_op(op_q[2], FL_RESET, "no internal reset");
		chk_bit(o_flash_access_led_pin, 1'b1, "indicator still on");
		chk_vec(32'(u_host.resp_q.size()), 32'd2, "end answered");
	endtask : t_end
	task automatic t_errors;
		logic [7:0] cmd [3] = '{CMD_END, CMD_START, CMD_START};
		logic [7:0] bad [3] = '{8'h00, 8'h5a, 8'h00};
		ufr_flop_t fo [3] = '{FL_NONE, FL_NONE, FL_INIT};
		int nops [3] = '{0, 0, 1};
		for (int c = 0; c < 3; c++)
		begin
			do_reset();
			fail_op = fo[c];
			u_host.send_pkt(cmd[c], 0, bad[c]);
			for (int i = 0; i < 3000 && o_error !== 1'b1; i++) @(posedge i_clk_sys);
			repeat (1000) @(posedge i_clk_sys);
			chk_bit(o_error, 1'b1, "no error stop");
			chk_vec(32'(op_q.size()), 32'(nops[c]), "work after error");
			chk_vec(32'(u_host.resp_q.size()), 32'd0, "answer after error");
		end
	endtask : t_errors
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		errors = 0;
		checks_done = 0;
		i_rst_n = 1'b0;
		i_fl_done = 1'b0;
		i_fl_fail = 1'b0;
		i_fl_blank = 1'b1;
		i_fl_win_start = 8'h00;
		i_fl_win_end = 8'h3f;
		fail_op = FL_NONE;
		served = 1'b0;
		wait_n = 0;
		wr_n = 0;
		wr_bad = 0;
		do_reset();
		t_start();
		t_write();
		t_end();
		t_errors();
		end_of_test();
	end
	// Full run is close to 50000 cycles; the limit leaves margin for slow answers.
	initial
	begin
		repeat (80000) @(posedge i_clk_sys);
		errors++;
		end_of_test();
	end
endmodule : ufr_sequencer_test
`default_nettype wire
